// file: gis_pkg.sv
package gis_pkg;

   // Register map, byte addresses
   localparam logic [15:0] STATUS_PAGE_ADDRESS_OFFSET = 16'h2080;
   localparam logic [15:0] STATUS_WRITE_MASK_OFFSET = 16'h2098;
   localparam logic [15:0] INTERRUPT_ENABLE_OFFSET = 16'h20A0;
   localparam logic [15:0] INTERRUPT_IDENTITY_OFFSET = 16'h20A4;
   localparam logic [15:0] INTERRUPT_MASK_OFFSET = 16'h20A8;
   localparam logic [15:0] INTERRUPT_LIVE_STATUS_OFFSET = 16'h20AC;
   localparam logic [15:0] ERROR_IDENTITY_OFFSET = 16'h20B0;
   localparam logic [15:0] ERROR_MASK_OFFSET = 16'h20B4;
   localparam logic [15:0] ERROR_LIVE_STATUS_OFFSET = 16'h20B8;

   // Reset values
   localparam logic [31:0] STATUS_PAGE_ADDRESS_RESET = 32'h1FFFF000;
   localparam logic [31:0] STATUS_WRITE_MASK_RESET = 32'hFFFEDFFF;
   localparam logic [31:0] INTERRUPT_ENABLE_RESET = 32'h00000000;
   localparam logic [31:0] INTERRUPT_IDENTITY_RESET = 32'h00000000;
   localparam logic [31:0] INTERRUPT_MASK_RESET = 32'hFFFEDFFF;
   localparam logic [31:0] INTERRUPT_LIVE_STATUS_RESET = 32'h00000000;
   localparam logic [15:0] ERROR_IDENTITY_RESET = 16'h0000;
   localparam logic [15:0] ERROR_MASK_RESET = 16'hFFFD;

   // Field positions and layouts
   localparam int STATUS_WIDTH = 32;
   localparam int ERROR_WIDTH = 16;
   localparam int SYNC_STATUS_BIT = 12;
   localparam int FLIP_PENDING_BIT = 8;
   localparam int MASTER_ERROR_BIT = 15;
   localparam int USER_INTERRUPT_BIT = 1;
   localparam int FATAL_ERROR_LSB = 10;
   localparam int FATAL_ERROR_MSB = 15;
   localparam int COMMAND_ERROR_BIT = 9;
   localparam logic [15:0] FATAL_ERROR_BITS = 16'hFC00;
   localparam logic [31:0] STATUS_PAGE_ADDRESS_FIELD = 32'hFFFFF000;
   localparam logic [31:0] STATUS_SLOT_DWORD = 32'h00000000;
   localparam logic [31:0] DWORD_BYTES = 32'h00000004;

   typedef enum logic [0:0] {
      GIS_WRITE_IDLE,
      GIS_WRITE_BUSY
   } gis_write_state_type;

endpackage

// file: gis_status_writer.sv
`timescale 1ns/100ps

module gis_status_writer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Request from the status logic
   input wire logic trigger,
   input wire logic [31:0] status_word,
   input wire logic [31:0] page_base,
   // Memory write port
   output logic status_write_valid,
   input wire logic status_write_ready,
   output logic [31:0] status_write_address,
   output logic [31:0] status_write_data
);
   import gis_pkg::*;

   gis_write_state_type state;
   gis_write_state_type next_state;
   logic again;
   wire accepted = status_write_valid && status_write_ready;
   wire load = trigger && (state == GIS_WRITE_IDLE || accepted);

   assign status_write_valid = (state == GIS_WRITE_BUSY);

   always_comb begin
      next_state = state;
      unique case (state)
         GIS_WRITE_IDLE: begin
            if (trigger) begin
               next_state = GIS_WRITE_BUSY;
            end
         end
         GIS_WRITE_BUSY: begin
            if (accepted && !trigger && !again) begin
               next_state = GIS_WRITE_IDLE;
            end
         end
      endcase
   end

   // Change during a held write is sent again with the newest word
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= GIS_WRITE_IDLE;
         again <= 1'b0;
         status_write_address <= 32'h00000000;
         status_write_data <= 32'h00000000;
      end else begin
         state <= next_state;
         if (load || (accepted && again)) begin
            status_write_data <= status_word;
            status_write_address <= (page_base & STATUS_PAGE_ADDRESS_FIELD)
               + STATUS_SLOT_DWORD * DWORD_BYTES;
         end
         if (accepted) begin
            again <= 1'b0;
         end else if (trigger && state == GIS_WRITE_BUSY) begin
            again <= 1'b1;
         end
      end
   end

endmodule

// file: gis_interrupt_ctrl.sv
// Function
// - Unmasked status change, e.g. flip pending bit 8, writes status word; mask resets to FFFEDFFF.
// - Set identity bit with enable raises interrupt; disabled bits still readable.
// - Unmasked live status bits latch into identity until written with one.
// - Sync flush completion toggles status bit 12.
// - Interrupt mask zero passes status to identity; resets to FFFEDFFF.
// - Live status register is read-only, current conditions, reset zero.
// - User interrupt status is only a short pulse.
// - Master error status bit is OR of error identity bits.
// - Error status latches into error identity only when unmasked.
// - Error identity bits 9:0 stay set until written with one.
// - Bits 15:10 set on decode parser mapping error; cleared by reset only.
// - Bit 9 set on media decode parser command error.
// - Status word goes to DWord 0 of the status page.
`timescale 1ns/100ps

module gis_interrupt_ctrl (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Register access
   input wire logic [15:0] mmio_address,
   input wire logic mmio_write,
   input wire logic mmio_read,
   input wire logic [31:0] mmio_write_data,
   output logic [31:0] mmio_read_data,
   output logic mmio_read_valid,
   // Interrupt sources
   input wire logic [31:0] source_status,
   input wire logic sync_flush_done,
   input wire logic [15:0] error_source_status,
   input wire logic decode_parser_mapping_error,
   input wire logic decode_parser_command_error,
   // Processor interrupt
   output logic cpu_interrupt,
   // Status page write
   output logic status_write_valid,
   input wire logic status_write_ready,
   output logic [31:0] status_write_address,
   output logic [31:0] status_write_data
);
   import gis_pkg::*;

   generate
      if (SYNC_STATUS_BIT == MASTER_ERROR_BIT || FATAL_ERROR_MSB >= ERROR_WIDTH
            || COMMAND_ERROR_BIT >= FATAL_ERROR_LSB) begin : bad_layout
         $error("gis_interrupt_ctrl: inconsistent bit layout");
      end
   endgenerate

   function automatic logic hit(input logic [15:0] address, input logic [15:0] offset);
      hit = (address == offset);
   endfunction

   // Registers
   logic [31:0] status_page_address;
   logic [31:0] status_write_mask;
   logic [31:0] interrupt_enable;
   logic [31:0] interrupt_identity;
   logic [31:0] interrupt_mask;
   logic [31:0] interrupt_live_status;
   logic [15:0] error_identity;
   logic [15:0] error_mask;
   logic [15:0] error_live_status;
   logic sync_toggle;
   logic [31:0] previous_status;

   // Address decode
   wire write_page = mmio_write && hit(mmio_address, STATUS_PAGE_ADDRESS_OFFSET);
   wire write_status_mask = mmio_write && hit(mmio_address, STATUS_WRITE_MASK_OFFSET);
   wire write_enable = mmio_write && hit(mmio_address, INTERRUPT_ENABLE_OFFSET);
   wire write_identity = mmio_write && hit(mmio_address, INTERRUPT_IDENTITY_OFFSET);
   wire write_mask = mmio_write && hit(mmio_address, INTERRUPT_MASK_OFFSET);
   wire write_error_identity = mmio_write && hit(mmio_address, ERROR_IDENTITY_OFFSET);
   wire write_error_mask = mmio_write && hit(mmio_address, ERROR_MASK_OFFSET);

   // Error path
   wire [15:0] next_error_live;
   assign next_error_live[FATAL_ERROR_MSB:FATAL_ERROR_LSB] =
      {(FATAL_ERROR_MSB - FATAL_ERROR_LSB + 1){decode_parser_mapping_error}}
      | error_source_status[FATAL_ERROR_MSB:FATAL_ERROR_LSB];
   assign next_error_live[COMMAND_ERROR_BIT] = decode_parser_command_error
      | error_source_status[COMMAND_ERROR_BIT];
   assign next_error_live[COMMAND_ERROR_BIT-1:0] = error_source_status[COMMAND_ERROR_BIT-1:0];

   wire [15:0] error_set = error_live_status & ~error_mask;
   wire [15:0] error_clear = (write_error_identity ? mmio_write_data[15:0] : 16'h0000)
      & ~FATAL_ERROR_BITS;
   wire [15:0] next_error_identity = (error_identity & ~error_clear) | error_set;

   // Live status vector
   logic [31:0] next_live;
   always_comb begin
      next_live = source_status;
      next_live[SYNC_STATUS_BIT] = sync_toggle;
      next_live[MASTER_ERROR_BIT] = |error_identity;
   end

   // Interrupt identity path
   wire [31:0] identity_set = interrupt_live_status & ~interrupt_mask;
   wire [31:0] identity_clear = write_identity ? mmio_write_data : 32'h00000000;
   wire [31:0] next_identity = (interrupt_identity & ~identity_clear) | identity_set;

   // Status change that is unmasked for the status page write
   wire [31:0] changed = interrupt_live_status ^ previous_status;
   wire status_trigger = |(changed & ~status_write_mask);

   assign cpu_interrupt = |(interrupt_identity & interrupt_enable);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sync_toggle <= 1'b0;
         previous_status <= INTERRUPT_LIVE_STATUS_RESET;
         interrupt_live_status <= INTERRUPT_LIVE_STATUS_RESET;
         error_live_status <= 16'h0000;
      end else begin
         if (sync_flush_done) begin
            sync_toggle <= ~sync_toggle;
         end
         previous_status <= interrupt_live_status;
         interrupt_live_status <= next_live;
         error_live_status <= next_error_live;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         interrupt_identity <= INTERRUPT_IDENTITY_RESET;
         error_identity <= ERROR_IDENTITY_RESET;
      end else begin
         interrupt_identity <= next_identity;
         error_identity <= next_error_identity;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         status_page_address <= STATUS_PAGE_ADDRESS_RESET;
         status_write_mask <= STATUS_WRITE_MASK_RESET;
         interrupt_enable <= INTERRUPT_ENABLE_RESET;
         interrupt_mask <= INTERRUPT_MASK_RESET;
         error_mask <= ERROR_MASK_RESET;
      end else begin
         if (write_page) begin
            status_page_address <= mmio_write_data & STATUS_PAGE_ADDRESS_FIELD;
         end
         if (write_status_mask) begin
            status_write_mask <= mmio_write_data;
         end
         if (write_enable) begin
            interrupt_enable <= mmio_write_data;
         end
         if (write_mask) begin
            interrupt_mask <= mmio_write_data;
         end
         if (write_error_mask) begin
            error_mask <= mmio_write_data[15:0];
         end
      end
   end

   // Read path, one cycle latency; unmapped addresses read zero
   logic [31:0] next_read_data;
   always_comb begin
      next_read_data = 32'h00000000;
      if (hit(mmio_address, STATUS_PAGE_ADDRESS_OFFSET)) begin
         next_read_data = status_page_address;
      end else if (hit(mmio_address, STATUS_WRITE_MASK_OFFSET)) begin
         next_read_data = status_write_mask;
      end else if (hit(mmio_address, INTERRUPT_ENABLE_OFFSET)) begin
         next_read_data = interrupt_enable;
      end else if (hit(mmio_address, INTERRUPT_IDENTITY_OFFSET)) begin
         next_read_data = interrupt_identity;
      end else if (hit(mmio_address, INTERRUPT_MASK_OFFSET)) begin
         next_read_data = interrupt_mask;
      end else if (hit(mmio_address, INTERRUPT_LIVE_STATUS_OFFSET)) begin
         next_read_data = interrupt_live_status;
      end else if (hit(mmio_address, ERROR_IDENTITY_OFFSET)) begin
         next_read_data = {16'h0000, error_identity};
      end else if (hit(mmio_address, ERROR_MASK_OFFSET)) begin
         next_read_data = {16'h0000, error_mask};
      end else if (hit(mmio_address, ERROR_LIVE_STATUS_OFFSET)) begin
         next_read_data = {16'h0000, error_live_status};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mmio_read_data <= 32'h00000000;
         mmio_read_valid <= 1'b0;
      end else begin
         mmio_read_valid <= mmio_read;
         if (mmio_read) begin
            mmio_read_data <= next_read_data;
         end
      end
   end

   gis_status_writer u_gis_status_writer (
      .sys_clk(sys_clk),
      .reset(reset),
      .trigger(status_trigger),
      .status_word(interrupt_live_status),
      .page_base(status_page_address),
      .status_write_valid(status_write_valid),
      .status_write_ready(status_write_ready),
      .status_write_address(status_write_address),
      .status_write_data(status_write_data)
   );

endmodule

// file: gis_interrupt_ctrl_checker.sv
`timescale 1ns/100ps

module gis_interrupt_ctrl_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Register access
   input wire logic [15:0] mmio_address,
   input wire logic mmio_write,
   input wire logic mmio_read,
   input wire logic [31:0] mmio_write_data,
   input wire logic [31:0] mmio_read_data,
   input wire logic mmio_read_valid,
   // Sources and outputs
   input wire logic [31:0] source_status,
   input wire logic cpu_interrupt,
   input wire logic status_write_valid,
   input wire logic status_write_ready,
   input wire logic [31:0] status_write_address,
   input wire logic [31:0] status_write_data
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence write_wait;
      status_write_valid && !status_write_ready;
   endsequence
   sequence write_held;
      status_write_valid && $stable(status_write_address) && $stable(status_write_data);
   endsequence

   read_answer_a: assert property (mmio_read |=> mmio_read_valid)
      else $error("read strobe not answered");
   read_pulse_a: assert property (!mmio_read |=> !mmio_read_valid)
      else $error("read valid without read");
   read_stands_a: assert property (!mmio_read |=> $stable(mmio_read_data))
      else $error("read data moved without read");
   unmapped_zero_a: assert property (mmio_read && mmio_address == 16'h3000 |=>
      mmio_read_data == 32'h0) else $error("unmapped read not zero");
   live_status_a: assert property (mmio_read && mmio_address == 16'h20AC |=>
      mmio_read_data[11:0] == $past(source_status[11:0], 2))
      else $error("live status read wrong");
   write_hold_a: assert property (write_wait |=> write_held)
      else $error("status write dropped before acceptance");
   write_slot_a: assert property (status_write_valid |->
      status_write_address[11:0] == 12'h0) else $error("status word not at slot zero");
   irq_disable_a: assert property (mmio_write && mmio_address == 16'h20A0 &&
      mmio_write_data == 32'h0 |=> !cpu_interrupt)
      else $error("interrupt with all enables off");
endmodule

bind gis_interrupt_ctrl gis_interrupt_ctrl_checker u_gis_interrupt_ctrl_checker (.sys_clk,
   .reset, .mmio_address, .mmio_write, .mmio_read, .mmio_write_data, .mmio_read_data,
   .mmio_read_valid, .source_status, .cpu_interrupt, .status_write_valid,
   .status_write_ready, .status_write_address, .status_write_data);

// file: gis_status_memory_model.sv
`timescale 1ns/100ps

module gis_status_memory_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Status page write port
   input wire logic status_write_valid,
   output logic status_write_ready,
   input wire logic [31:0] status_write_address,
   input wire logic [31:0] status_write_data,
   // Bench control and observation
   input wire logic mem_stall,
   output logic [31:0] seen_address,
   output logic [31:0] seen_data,
   output int n_writes
);
   // One-cycle accept pulse, withheld while stalled
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         status_write_ready <= 1'h0;
         n_writes <= 0;
      end else begin
         status_write_ready <= status_write_valid && !mem_stall && !status_write_ready;
         if (status_write_valid && status_write_ready) begin
            seen_address <= status_write_address;
            seen_data <= status_write_data;
            n_writes <= n_writes + 1;
         end
      end
   end
endmodule

// file: gis_interrupt_ctrl_test.sv
`timescale 1ns/100ps

module gis_interrupt_ctrl_test;
   import gis_pkg::*;
   logic sys_clk = 1'h0;
   logic reset = 1'h1;
   logic mmio_write = 1'h0;
   logic mmio_read = 1'h0;
   logic sync_flush_done = 1'h0;
   logic decode_parser_mapping_error = 1'h0;
   logic decode_parser_command_error = 1'h0;
   logic mem_stall = 1'h1;
   logic [15:0] mmio_address = 16'h0;
   logic [15:0] error_source_status = 16'h0;
   logic [31:0] mmio_write_data = 32'h0;
   logic [31:0] source_status = 32'h0;
   logic [31:0] mmio_read_data, rd_data, status_write_address, status_write_data;
   logic [31:0] seen_address, seen_data;
   logic mmio_read_valid, cpu_interrupt, status_write_valid, status_write_ready;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n_writes;

   always #50 sys_clk = ~sys_clk;

   gis_interrupt_ctrl u_gis_interrupt_ctrl (.sys_clk, .reset, .mmio_address, .mmio_write,
      .mmio_read, .mmio_write_data, .mmio_read_data, .mmio_read_valid, .source_status,
      .sync_flush_done, .error_source_status, .decode_parser_mapping_error,
      .decode_parser_command_error, .cpu_interrupt, .status_write_valid,
      .status_write_ready, .status_write_address, .status_write_data);
   gis_status_memory_model u_gis_status_memory_model (.sys_clk, .reset, .status_write_valid,
      .status_write_ready, .status_write_address, .status_write_data, .mem_stall,
      .seen_address, .seen_data, .n_writes);

   task tick;
      @(posedge sys_clk);
      #10;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [15:0] addr, input logic [31:0] data);
      mmio_address = addr;
      mmio_write_data = data;
      mmio_write = 1'h1;
      tick;
      mmio_write = 1'h0;
      // Idle cycle keeps back-to-back strobes apart
      tick;
   endtask
   task rd(input logic [15:0] addr);
      mmio_address = addr;
      mmio_read = 1'h1;
      tick;
      mmio_read = 1'h0;
      rd_data = mmio_read_data;
      tick;
   endtask
   task finish_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task t_regs;
      logic [15:0] addrs [5] = '{16'h20A0, 16'h20A4, 16'h20A8, 16'h20AC, 16'h2098};
      logic [31:0] inits [5] = '{32'h0, 32'h0, 32'hFFFEDFFF, 32'h0, 32'hFFFEDFFF};
      for (int i = 0; i < 5; i++) begin
         rd(addrs[i]);
         chk(rd_data, inits[i]);
      end
      wr(16'h20AC, 32'hFFFFFFFF);
      rd(16'h20AC);
      chk(rd_data, 32'h0);
      rd(16'h3000);
      chk(rd_data, 32'h0);
   endtask
   task t_latch;
      wr(16'h20A8, 32'hFFFEDFF7);
      source_status = 32'h18;
      repeat (3) tick;
      rd(16'h20A4);
      chk(rd_data, 32'h8);
      chk(32'(cpu_interrupt), 32'h0);
      wr(16'h20A0, 32'h8);
      chk(32'(cpu_interrupt), 32'h1);
      wr(16'h20A4, 32'h8);
      rd(16'h20A4);
      chk(rd_data, 32'h8);
      source_status = 32'h0;
      repeat (2) tick;
      wr(16'h20A4, 32'h8);
      rd(16'h20A4);
      chk(rd_data, 32'h0);
      chk(32'(cpu_interrupt), 32'h0);
      wr(16'h20A0, 32'h0);
   endtask
   task t_pulse;
      wr(16'h20A8, 32'hFFFEDFF5);
      source_status = 32'h2;
      tick;
      source_status = 32'h0;
      repeat (3) tick;
      rd(16'h20AC);
      chk(rd_data, 32'h0);
      rd(16'h20A4);
      chk(rd_data, 32'h2);
      wr(16'h20A4, 32'h2);
      rd(16'h20A4);
      chk(rd_data, 32'h0);
   endtask
   task flush_pulse;
      sync_flush_done = 1'h1;
      tick;
      sync_flush_done = 1'h0;
      repeat (2) tick;
   endtask
   task t_sync;
      flush_pulse;
      rd(16'h20AC);
      chk(rd_data, 32'h1000);
      flush_pulse;
      rd(16'h20AC);
      chk(rd_data, 32'h0);
   endtask
   task t_status_write;
      wr(16'h2098, 32'hFFFFFEFF);
      source_status = 32'h100;
      for (int i = 0; i < 20 && !status_write_valid; i++) tick;
      chk(status_write_address, 32'h1FFFF000);
      chk(status_write_data, 32'h100);
      // Change while the write waits: word held, then sent again
      source_status = 32'h10;
      repeat (3) tick;
      chk(status_write_data, 32'h100);
      chk(32'(status_write_valid), 32'h1);
      mem_stall = 1'h0;
      repeat (8) tick;
      chk(32'(n_writes), 32'h2);
      chk(seen_data, 32'h10);
      chk(seen_address, 32'h1FFFF000);
      source_status = 32'h0;
      repeat (6) tick;
      chk(32'(n_writes), 32'h2);
      chk(32'(status_write_valid), 32'h0);
   endtask
   task t_errors;
      wr(16'h20B4, 32'h0);
      decode_parser_mapping_error = 1'h1;
      decode_parser_command_error = 1'h1;
      error_source_status = 16'h1;
      tick;
      decode_parser_mapping_error = 1'h0;
      decode_parser_command_error = 1'h0;
      error_source_status = 16'h0;
      repeat (5) tick;
      rd(16'h20B0);
      chk(rd_data, 32'hFE01);
      rd(16'h20AC);
      chk(rd_data, 32'h8000);
      wr(16'h20B0, 32'hFFFF);
      rd(16'h20B0);
      chk(rd_data, 32'hFC00);
      wr(16'h20B4, 32'hFFFF);
      error_source_status = 16'h2;
      repeat (4) tick;
      rd(16'h20B0);
      chk(rd_data, 32'hFC00);
      error_source_status = 16'h0;
   endtask
   task t_reset;
      reset = 1'h1;
      repeat (2) tick;
      reset = 1'h0;
      tick;
      chk(32'(status_write_valid), 32'h0);
      rd(16'h20B0);
      chk(rd_data, 32'h0);
      rd(16'h20AC);
      chk(rd_data, 32'h0);
      rd(16'h20A8);
      chk(rd_data, 32'hFFFEDFFF);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         finish_test;
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      #10 reset = 1'h0;
      tick;
      t_regs;
      t_latch;
      t_pulse;
      t_sync;
      t_status_write;
      t_errors;
      t_reset;
      finish_test;
   end
endmodule
